// File: verilog/adc_dev_end.sv
// converter end: setup word capture, conversion timing, result shift-out
`timescale 1ns/10ps
module adc_dev_end
(
    // system side
    input  wire logic                          I_SYS_CLK,
    input  wire logic                          I_RSTN,
    input  wire logic [adc_pkg::RES_W-1:0]     I_SAMPLE,
    // link
    adc_link_if.dev                            LINK,
    // converter state
    output logic      [adc_pkg::CFG_W-1:0]     O_CFG,
    output logic                               O_REF_4V096,
    output logic                               O_TEMP_ON,
    output logic      [2:0]                    O_CHANNEL,
    output logic                               O_TEMP_SEL,
    output logic                               O_CONVERTING,
    output logic                               O_EOC
);
    import adc_pkg::*;

    // ==================================================================
    // link side: frame logic is reset by the start line itself
    logic                link_rst;
    logic [CFG_W-1:0]    cap_ff;
    logic [4:0]          cap_cnt_ff;
    logic                cap_full_ff;
    logic [4:0]          fall_cnt_ff;
    logic [4:0]          fall_limit;
    logic [4:0]          bit_sel;
    logic [FRAME_W-1:0]  frame_word;

    assign link_rst = LINK.convert_start_line | ~I_RSTN;

    // start line high ignores the input line
    always_ff @(posedge LINK.sck or posedge link_rst)
    begin
        if (link_rst)
        begin
            cap_cnt_ff  <= 5'h00;
            cap_full_ff <= 1'b0;
        end
        else if (cap_cnt_ff < CAP_BITS)
        begin
            cap_cnt_ff  <= cap_cnt_ff + 5'h01;
            cap_full_ff <= (cap_cnt_ff == CAP_BITS - 5'h01);
        end
    end

    // word kept past frame end so the system side can take it
    always_ff @(posedge LINK.sck or negedge I_RSTN)
    begin
        if (!I_RSTN)
            cap_ff <= '0;
        else if (!link_rst && cap_cnt_ff < CAP_BITS)
            cap_ff <= {cap_ff[CFG_W-2:0], LINK.din};
    end

    logic [RES_W-1:0] res_ff;
    logic [CFG_W-1:0] echo_ff;
    logic             echo_off_ff;
    logic             avail_ff;

    assign fall_limit = echo_off_ff ? EDGES_SHORT : EDGES_ECHO;
    assign frame_word = {res_ff, echo_ff};
    assign bit_sel    = FRAME_LAST - fall_cnt_ff;

    always_ff @(negedge LINK.sck or posedge link_rst)
    begin
        if (link_rst)
            fall_cnt_ff <= 5'h00;
        else if (fall_cnt_ff != fall_limit)
            fall_cnt_ff <= fall_cnt_ff + 5'h01;
    end

    // result words only change at end of conversion, while the line is high
    assign LINK.sdo_o  = (fall_cnt_ff <= FRAME_LAST) ?
                         frame_word[bit_sel] : 1'b0;
    assign LINK.sdo_oe = ~LINK.convert_start_line & I_RSTN & avail_ff
                         & (fall_cnt_ff != fall_limit);

    // ==================================================================
    // system side synchronisers
    logic [2:0] cnv_sync_ff;
    logic [2:0] full_sync_ff;
    logic       cnv_lvl_ff;
    logic       full_lvl_ff;
    logic       cnv_rise;
    logic       full_rise;

    always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            cnv_sync_ff  <= 3'h0;
            full_sync_ff <= 3'h0;
        end
        else
        begin
            cnv_sync_ff  <= {cnv_sync_ff[1:0], LINK.convert_start_line};
            full_sync_ff <= {full_sync_ff[1:0], cap_full_ff};
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            cnv_lvl_ff  <= 1'b0;
            full_lvl_ff <= 1'b0;
        end
        else
        begin
            if (cnv_sync_ff[2] == cnv_sync_ff[1])
                cnv_lvl_ff <= cnv_sync_ff[2];
            if (full_sync_ff[2] == full_sync_ff[1])
                full_lvl_ff <= full_sync_ff[2];
        end
    end

    assign cnv_rise  = (cnv_sync_ff[2] == cnv_sync_ff[1]) & cnv_sync_ff[2] & ~cnv_lvl_ff;
    assign full_rise = (full_sync_ff[2] == full_sync_ff[1]) & full_sync_ff[2] & ~full_lvl_ff;

    // ==================================================================
    // conversion timing on the internal clock
    logic [11:0]      conv_cnt_ff;
    logic             converting_ff;
    logic             eoc;
    logic [RES_W-1:0] sample_ff;

    assign eoc = converting_ff & (conv_cnt_ff == CONV_LAST);

    // a started conversion runs to the end whatever the start line does
    always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            converting_ff <= 1'b0;
            conv_cnt_ff   <= 12'h000;
            sample_ff     <= '0;
        end
        else if (cnv_rise && !converting_ff)
        begin
            converting_ff <= 1'b1;
            conv_cnt_ff   <= 12'h000;
            sample_ff     <= I_SAMPLE;
        end
        else if (eoc)
            converting_ff <= 1'b0;
        else if (converting_ff)
            conv_cnt_ff <= conv_cnt_ff + 12'h001;
    end

    // ==================================================================
    // setup word: pending until end of conversion, then committed
    logic [CFG_W-1:0] pend_ff;
    logic             pend_vld_ff;
    logic [CFG_W-1:0] cfg_ff;
    logic [CFG_W-1:0] nxt_cfg;
    logic [1:0]       eoc_num_ff;

    always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
            pend_ff <= CFG_RESET;
        else if (full_rise)
            pend_ff <= cap_ff;
    end

    // a word that lands in the end cycle survives into the next phase
    always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
            pend_vld_ff <= 1'b0;
        else if (full_rise)
            pend_vld_ff <= 1'b1;
        else if (eoc)
            pend_vld_ff <= 1'b0;
    end

    // first end after power-up never commits
    assign nxt_cfg = (pend_vld_ff && !full_rise && eoc_num_ff != 2'h0) ?
                     pend_ff : cfg_ff;

    always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            cfg_ff     <= CFG_RESET;
            eoc_num_ff <= 2'h0;
        end
        else if (eoc)
        begin
            cfg_ff <= nxt_cfg;
            if (eoc_num_ff != 2'h3)
                eoc_num_ff <= eoc_num_ff + 2'h1;
        end
    end

    // result and matching setup replace any unread frame
    always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            res_ff      <= '0;
            echo_ff     <= '0;
            echo_off_ff <= 1'b1;
            avail_ff    <= 1'b0;
        end
        else if (eoc)
        begin
            res_ff      <= sample_ff;
            echo_ff     <= nxt_cfg;
            echo_off_ff <= nxt_cfg[ECHO_OFF_B];
            avail_ff    <= 1'b1;
        end
    end

    // ==================================================================
    // channel scanning, updated at each end of conversion; scan off selects the last channel instead of advancing
    logic [2:0] chan_ff;
    logic       temp_sel_ff;
    logic [1:0] scan;
    logic [1:0] scan_old;
    logic [2:0] last_ch;

    assign scan     = nxt_cfg[SCAN_HI:SCAN_LO];
    assign scan_old = cfg_ff[SCAN_HI:SCAN_LO];
    assign last_ch  = nxt_cfg[LAST_HI:LAST_LO];

    always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            chan_ff     <= 3'h0;
            temp_sel_ff <= 1'b0;
        end
        else if (eoc)
        begin
            unique case (scan)
                SCAN_OFF:
                begin
                    chan_ff     <= last_ch;
                    temp_sel_ff <= 1'b0;
                end
                SCAN_KEEP:
                begin
                    if (chan_ff == last_ch || temp_sel_ff)
                        chan_ff <= 3'h0;
                    else
                        chan_ff <= chan_ff + 3'h1;
                    temp_sel_ff <= 1'b0;
                end
                SCAN_TEMP, SCAN_NOTEMP:
                begin
                    if (scan_old == SCAN_OFF || temp_sel_ff)
                    begin
                        chan_ff     <= 3'h0;
                        temp_sel_ff <= 1'b0;
                    end
                    else if (chan_ff == last_ch && scan == SCAN_TEMP)
                        temp_sel_ff <= 1'b1;
                    else if (chan_ff == last_ch)
                        chan_ff <= 3'h0;
                    else
                        chan_ff <= chan_ff + 3'h1;
                end
            endcase
        end
    end

    // ==================================================================
    // outputs
    always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
            O_EOC <= 1'b0;
        else
            O_EOC <= eoc;
    end

    assign O_CFG        = cfg_ff;
    assign O_REF_4V096  = (cfg_ff[REF_HI:REF_LO] == REF_4V096);
    assign O_TEMP_ON    = O_REF_4V096 | ~cfg_ff[REF_HI];
    assign O_CHANNEL    = chan_ff;
    assign O_TEMP_SEL   = temp_sel_ff;
    assign O_CONVERTING = converting_ff;

endmodule

// File: verilog/adc_pkg.sv
// shared constants for the converter link, device end and host end
package adc_pkg;

    // ==================================================================
    // word layout
    localparam int CFG_W      = 14;
    localparam int RES_W      = 16;
    localparam int FRAME_W    = RES_W + CFG_W;
    localparam int ECHO_OFF_B = 0;
    localparam int SCAN_LO    = 1;
    localparam int SCAN_HI    = 2;
    localparam int REF_LO     = 3;
    localparam int REF_HI     = 5;
    localparam int LAST_LO    = 7;
    localparam int LAST_HI    = 9;

    localparam logic [CFG_W-1:0] CFG_RESET   = 14'h3FFF;
    localparam logic [2:0]       REF_4V096   = 3'h2;
    localparam logic [1:0]       SCAN_OFF    = 2'h0;
    localparam logic [1:0]       SCAN_KEEP   = 2'h1;
    localparam logic [1:0]       SCAN_TEMP   = 2'h2;
    localparam logic [1:0]       SCAN_NOTEMP = 2'h3;

    // ==================================================================
    // frame lengths in falling serial clock edges; capture bits counted on rising edges
    localparam logic [4:0] EDGES_SHORT = 5'h10;
    localparam logic [4:0] EDGES_ECHO  = 5'h1E;
    localparam logic [4:0] CAP_BITS    = 5'h0E;
    localparam logic [4:0] FRAME_LAST  = 5'h1D;

    // ==================================================================
    // timing
    localparam int CLK_NS       = 4;
    localparam int CONV_TIME_NS = 2200;
    localparam int CONV_CYC     = (CONV_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOST_MARGIN  = 16;
    localparam int WAIT_CYC     = CONV_CYC + HOST_MARGIN;
    localparam int SCK_HALF_CYC = 6;
    localparam logic [11:0] CONV_LAST = 12'(CONV_CYC - 1);
    localparam logic [11:0] WAIT_LAST = 12'(WAIT_CYC - 1);
    localparam logic [2:0]  HALF_LAST = 3'(SCK_HALF_CYC - 1);
    localparam logic [15:0] UNDEF_RESULTS = 16'h0003;

    // ==================================================================
    // host register map
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_RESULT = 8'h08;
    localparam logic [7:0] OFS_PHASE  = 8'h0C;
    localparam int CTRL_START_B = 0;
    localparam int CTRL_CFG_LO  = 16;
    localparam int ST_BUSY_B    = 0;
    localparam int ST_DONE_B    = 1;
    localparam int ST_UNDEF_B   = 2;
    localparam int RES_ECHO_LO  = 16;

endpackage

// File: verilog/adc_link_if.sv
// serial link between converter and host
`timescale 1ns/10ps
interface adc_link_if;
    logic sck;
    logic convert_start_line;
    logic din;
    logic sdo_o;
    logic sdo_oe;
    logic result_out_line;

    // undriven line reads low
    assign result_out_line = sdo_oe ? sdo_o : 1'b0;

    modport dev
    (
        input  sck,
        input  convert_start_line,
        input  din,
        output sdo_o,
        output sdo_oe
    );

    modport host
    (
        output sck,
        output convert_start_line,
        output din,
        input  result_out_line
    );
endinterface

// File: verilog/adc_host_end.sv
// host end: APB-controlled conversion start, serial clock and frame transfer
`timescale 1ns/10ps
module adc_host_end
(
    // system
    input  wire logic              I_SYS_CLK,
    input  wire logic              I_RSTN,
    // APB slave
    input  wire logic              I_PSEL,
    input  wire logic              I_PENABLE,
    input  wire logic              I_PWRITE,
    input  wire logic [7:0]        I_PADDR,
    input  wire logic [31:0]       I_PWDATA,
    output logic      [31:0]       O_PRDATA,
    output logic                   O_PREADY,
    output logic                   O_PSLVERR,
    // link
    adc_link_if.host               LINK
);
    import adc_pkg::*;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_XFER = 2'b11,
        ST_HOLD = 2'b10
    } host_st_e;

    // ==================================================================
    // register access
    host_st_e          state_ff;
    logic              wr_acc;
    logic              start;
    logic [CFG_W-1:0]  setup_ff;
    logic [RES_W-1:0]  res_ff;
    logic [CFG_W-1:0]  echo_ff;
    logic              done_ff;
    logic              undef_ff;
    logic [15:0]       conv_num_ff;
    logic              mapped;

    assign wr_acc = I_PSEL & I_PENABLE & I_PWRITE;
    assign start  = wr_acc & (I_PADDR == OFS_CTRL) & I_PWDATA[CTRL_START_B]
                    & (state_ff == ST_IDLE);
    assign mapped = (I_PADDR == OFS_CTRL) | (I_PADDR == OFS_STATUS)
                    | (I_PADDR == OFS_RESULT) | (I_PADDR == OFS_PHASE);
    assign O_PREADY  = 1'b1;
    assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;

    always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
            setup_ff <= CFG_RESET;
        else if (wr_acc && I_PADDR == OFS_CTRL)
            setup_ff <= I_PWDATA[CTRL_CFG_LO +: CFG_W];
    end

    always_comb
    begin
        O_PRDATA = 32'h0000_0000;
        unique case (1'b1)
            I_PADDR == OFS_CTRL:   O_PRDATA[CTRL_CFG_LO +: CFG_W] = setup_ff;
            I_PADDR == OFS_STATUS:
            begin
                O_PRDATA[ST_BUSY_B]  = (state_ff != ST_IDLE);
                O_PRDATA[ST_DONE_B]  = done_ff;
                O_PRDATA[ST_UNDEF_B] = undef_ff;
            end
            I_PADDR == OFS_RESULT:
            begin
                O_PRDATA[RES_W-1:0]                = res_ff;
                O_PRDATA[RES_ECHO_LO +: CFG_W]     = echo_ff;
            end
            I_PADDR == OFS_PHASE:  O_PRDATA[15:0] = conv_num_ff;
            default:               O_PRDATA = 32'h0000_0000;
        endcase
    end

    // ==================================================================
    // returning line through three synchroniser flops and a level flop
    logic [2:0] sdo_sync_ff;
    logic       sdo_lvl_ff;

    always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            sdo_sync_ff <= 3'h0;
            sdo_lvl_ff  <= 1'b0;
        end
        else
        begin
            sdo_sync_ff <= {sdo_sync_ff[1:0], LINK.result_out_line};
            if (sdo_sync_ff[2] == sdo_sync_ff[1])
                sdo_lvl_ff <= sdo_sync_ff[2];
        end
    end

    // ==================================================================
    // sequence: start high for the conversion, then one low frame
    logic [11:0]        wait_ff;
    logic [2:0]         half_ff;
    logic               sck_ff;
    logic               cnv_ff;
    logic [CFG_W-1:0]   tx_ff;
    logic [FRAME_W-1:0] rx_ff;
    logic [4:0]         edge_ff;
    logic [4:0]         nedge_ff;
    logic [CFG_W-1:0]   sent_ff;
    logic               eff_off_ff;

    always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            state_ff <= ST_IDLE;
            wait_ff  <= 12'h000;
            half_ff  <= 3'h0;
            sck_ff   <= 1'b0;
            cnv_ff   <= 1'b0;
            tx_ff    <= '0;
            rx_ff    <= '0;
            edge_ff  <= 5'h00;
            nedge_ff <= EDGES_SHORT;
        end
        else
        begin
            unique case (state_ff)
                ST_IDLE:
                    if (start)
                    begin
                        cnv_ff   <= 1'b1;
                        wait_ff  <= 12'h000;
                        state_ff <= ST_CONV;
                    end
                ST_CONV:
                    if (wait_ff == WAIT_LAST)
                    begin
                        cnv_ff   <= 1'b0;
                        tx_ff    <= setup_ff;
                        half_ff  <= 3'h0;
                        edge_ff  <= 5'h00;
                        nedge_ff <= eff_off_ff ? EDGES_SHORT : EDGES_ECHO;
                        state_ff <= ST_XFER;
                    end
                    else
                        wait_ff <= wait_ff + 12'h001;
                ST_XFER:
                    if (half_ff == HALF_LAST)
                    begin
                        half_ff <= 3'h0;
                        sck_ff  <= ~sck_ff;
                        if (sck_ff)
                        begin
                            rx_ff   <= {rx_ff[FRAME_W-2:0], sdo_lvl_ff};
                            tx_ff   <= {tx_ff[CFG_W-2:0], 1'b0};
                            edge_ff <= edge_ff + 5'h01;
                            if (edge_ff == nedge_ff - 5'h01)
                                state_ff <= ST_HOLD;
                        end
                    end
                    else
                        half_ff <= half_ff + 3'h1;
                ST_HOLD:
                    if (half_ff == HALF_LAST)
                        state_ff <= ST_IDLE;
                    else
                        half_ff <= half_ff + 3'h1;
            endcase
        end
    end

    // ==================================================================
    // phase tracking and result hand-off
    always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            conv_num_ff <= 16'h0000;
            sent_ff     <= CFG_RESET;
            eff_off_ff  <= 1'b1;
        end
        else if (start)
        begin
            if (conv_num_ff != 16'hFFFF)
                conv_num_ff <= conv_num_ff + 16'h0001;
            if (conv_num_ff != 16'h0000)
                eff_off_ff <= sent_ff[ECHO_OFF_B];
        end
        else if (state_ff == ST_CONV && wait_ff == WAIT_LAST)
            sent_ff <= setup_ff;
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            done_ff  <= 1'b0;
            undef_ff <= 1'b0;
            res_ff   <= '0;
            echo_ff  <= '0;
        end
        else if (state_ff == ST_HOLD && half_ff == HALF_LAST)
        begin
            done_ff  <= 1'b1;
            undef_ff <= (conv_num_ff <= UNDEF_RESULTS);
            if (nedge_ff == EDGES_SHORT)
            begin
                res_ff  <= rx_ff[RES_W-1:0];
                echo_ff <= '0;
            end
            else
            begin
                res_ff  <= rx_ff[FRAME_W-1:CFG_W];
                echo_ff <= rx_ff[CFG_W-1:0];
            end
        end
        else if (start)
            done_ff <= 1'b0;
    end

    assign LINK.sck                = sck_ff;
    assign LINK.convert_start_line = cnv_ff;
    assign LINK.din                = tx_ff[CFG_W-1];

endmodule

// File: bench/adc_link_sva.sv
// assertions on the converter link signals
`timescale 1ns/10ps
module adc_link_sva
(
    // clock and reset
    input  wire logic I_SYS_CLK,
    input  wire logic I_RSTN,
    // link
    input  wire logic sck,
    input  wire logic convert_start_line,
    input  wire logic din,
    input  wire logic sdo_o,
    input  wire logic sdo_oe,
    input  wire logic result_out_line
);
    import adc_pkg::*;
    logic       sck_q;
    logic [4:0] fcnt;
    logic [9:0] hcnt;
    logic       fall;
    logic [4:0] edges;
    // falling edges seen in this frame, including one landing now
    assign fall  = sck_q & ~sck;
    assign edges = fcnt + 5'(fall);
    always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
            {sck_q, fcnt} <= '0;
        else
            {sck_q, fcnt} <= {sck, convert_start_line ? 5'h00 : edges};
    end
    always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
            hcnt <= '0;
        else if (convert_start_line)
            hcnt <= hcnt + 10'h001;
        else
            hcnt <= 10'h000;
    end
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RSTN);
    sequence s_frame_start; $fell(convert_start_line); endsequence
    property p_cnv_off; convert_start_line |-> !sdo_oe; endproperty
    property p_idle_low; convert_start_line |-> !sck; endproperty
    property p_msb; s_frame_start |-> ##[0:1] sdo_oe; endproperty
    property p_shift; sdo_oe && $past(sdo_oe) && !fall |-> $stable(sdo_o); endproperty
    property p_max; sdo_oe |-> edges < EDGES_ECHO; endproperty
    property p_release;
        $fell(sdo_oe) |-> convert_start_line || edges == EDGES_SHORT || edges == EDGES_ECHO;
    endproperty
    property p_edges;
        $rose(convert_start_line) && fcnt != 5'h00 |-> fcnt == EDGES_SHORT || fcnt == EDGES_ECHO;
    endproperty
    property p_hold; s_frame_start |-> hcnt >= 10'(CONV_CYC); endproperty
    a_cnv_off: assert property (p_cnv_off)
        else $error("result line driven while converting");
    a_idle_low: assert property (p_idle_low)
        else $error("serial clock not idle low");
    a_msb: assert property (p_msb)
        else $error("result line not driven at frame start");
    a_shift: assert property (p_shift)
        else $error("data bit changed off a falling edge");
    a_max: assert property (p_max)
        else $error("result line driven past last edge");
    a_release: assert property (p_release)
        else $error("result line released at wrong edge");
    a_edges: assert property (p_edges)
        else $error("frame edge count wrong");
    a_hold: assert property (p_hold)
        else $error("start line dropped before end of conversion");
endmodule

// File: bench/sar_adc_cfg_readout_no_busy_test.sv
// bench: host end and converter end joined on one link
`timescale 1ns/10ps
module sar_adc_cfg_readout_no_busy_test;
    import adc_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] sample = 16'h0000;
    logic [31:0] prdata, q;
    logic        pready, pslverr, err, ref4, temp_on;
    logic [13:0] cfg;
    logic [2:0]  chan;
    logic        temp_sel, conv_on, eoc_p;
    int          eocs = 0;
    logic [3:0]  chans [5] = '{4'h0, 4'h1, 4'h0, 4'h1, 4'h0};
    int          mismatches = 0;
    int          checks = 0;
    logic [13:0] words [5] = '{14'h3C90, 14'h3C92, 14'h3C94, 14'h3C97, 14'h3C10};
    always #2 clk = ~clk;
    adc_link_if adc_link_if_i ();
    adc_dev_end adc_dev_end_i (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_SAMPLE(sample),
        .LINK(adc_link_if_i), .O_CFG(cfg), .O_REF_4V096(ref4), .O_TEMP_ON(temp_on),
        .O_CHANNEL(chan), .O_TEMP_SEL(temp_sel), .O_CONVERTING(conv_on), .O_EOC(eoc_p));
    // conversions ended, counted from the end-of-conversion pulse
    always @(posedge clk)
        if (eoc_p === 1'b1)
            eocs <= eocs + 1;
    adc_host_end adc_host_end_i (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .LINK(adc_link_if_i));
    adc_link_sva adc_link_sva_i (.I_SYS_CLK(clk), .I_RSTN(rstn), .sck(adc_link_if_i.sck),
        .convert_start_line(adc_link_if_i.convert_start_line), .din(adc_link_if_i.din),
        .sdo_o(adc_link_if_i.sdo_o), .sdo_oe(adc_link_if_i.sdo_oe),
        .result_out_line(adc_link_if_i.result_out_line));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // one conversion plus the frame that follows it, then fetch the result
    task automatic run_conv(input logic [13:0] w, input logic [15:0] s);
        sample <= s;
        apb(1'b1, OFS_CTRL, {2'b00, w, 15'h0000, 1'b1});
        do apb(1'b0, OFS_STATUS, 32'h0); while (q[ST_DONE_B] !== 1'b1);
        apb(1'b0, OFS_RESULT, 32'h0);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        #(4 * 40000);
        mismatches++;
        print_verdict();
    end
    initial
    begin
        logic [13:0] prev;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        chk(32'(cfg), 32'(CFG_RESET));
        apb(1'b0, 8'h10, 32'h0);
        chk(q, 32'h0000_0000);
        chk(32'(err), 32'h0000_0001);
        run_conv(14'h3C10, 16'hA55A);
        chk(q, 32'h0000A55A);
        chk(32'(cfg), 32'(CFG_RESET));
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(32'(q[ST_UNDEF_B]), 32'h0000_0001);
        run_conv(14'h3C10, 16'h3C96);
        chk(32'({cfg, ref4, temp_on}), {16'h0000, 14'h3C10, 2'b11});
        chk(q, {2'b00, 14'h3C10, 16'h3C96});
        for (int i = 0; i < 5; i++)
        begin
            run_conv(words[i], 16'(16'h8001 + i));
            prev = (i == 0) ? 14'h3C10 : words[i - 1];
            chk(32'(cfg), 32'(prev));
            chk(32'({temp_sel, chan}), 32'(chans[i]));
            chk(q, {2'b00, prev[0] ? 14'h0 : prev, 16'(16'h8001 + i)});
        end
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(32'(q[ST_UNDEF_B]), 32'h0000_0000);
        chk(eocs, 32'h0000_0007);
        chk(32'(conv_on), 32'h0000_0000);
        print_verdict();
    end
endmodule
